// file: hw/spc_consts.vh
// Purpose: constants for the segment protection configuration decoder
// Assumes: byte-wide configuration words, one every two address units
// Notes:   definitions only
`ifndef SPC_CONSTS_VH
`define SPC_CONSTS_VH

// ************************************************************
// configuration word map
// ************************************************************
`define SPC_CFG_BASE        24'hf80000
`define SPC_CFG_LAST        24'hf80016
`define SPC_CFG_SPACE_LO    24'h800000
`define SPC_OFS_BOOT        24'hf80000
`define SPC_OFS_SECURE      24'hf80002
`define SPC_OFS_GENERAL     24'hf80004
`define SPC_OFS_OSC_SEL     24'hf80006
`define SPC_OFS_OSC         24'hf80008
`define SPC_OFS_WDT         24'hf8000a
`define SPC_OFS_POR         24'hf8000c
`define SPC_OFS_DEBUG       24'hf8000e
`define SPC_OFS_UID0        24'hf80010
`define SPC_OFS_UID1        24'hf80012
`define SPC_OFS_UID2        24'hf80014
`define SPC_OFS_UID3        24'hf80016

// ************************************************************
// implemented-bit masks, unimplemented bits read as zero
// ************************************************************
`define SPC_MASK_BOOT       8'hcf
`define SPC_MASK_SECURE     8'hcf
`define SPC_MASK_GENERAL    8'h07
`define SPC_MASK_OSC_SEL    8'h87
`define SPC_MASK_OSC        8'he7
`define SPC_MASK_WDT        8'hdf
`define SPC_MASK_POR        8'hf7
`define SPC_MASK_DEBUG      8'he3
`define SPC_MASK_UID        8'hff
`define SPC_ABSENT_WORD     8'hff
`define SPC_ERASED_WORD     8'hff

// ************************************************************
// field positions in boot and secure words
// ************************************************************
`define SPC_WRP_BIT         0
`define SPC_SIZE_LO         1
`define SPC_SIZE_HI         3
`define SPC_RAM_LO          6
`define SPC_RAM_HI          7

// ************************************************************
// segment end addresses and ram sizes
// ************************************************************
`define SPC_END_1K          24'h0007fe
`define SPC_END_4K          24'h001ffe
`define SPC_END_8K          24'h003ffe
`define SPC_END_16K         24'h007ffe
`define SPC_BRAM_128        13'd128
`define SPC_BRAM_256        13'd256
`define SPC_BRAM_1024       13'd1024
`define SPC_SRAM_256        13'd256
`define SPC_SRAM_2048       13'd2048
`define SPC_SRAM_4096       13'd4096

`endif

// file: hw/spc_segment_decode.v
// Purpose: holds the configuration words, decodes boot and secure protection
// Assumes: programming agent drives word writes; table port is the only path
// Notes:   decoded settings are latched at reset and stay steady afterwards
//
// How it works
// - programmed bits read zero; erased bits read one
// - words sit from the base, one per two address units, through last id byte
// - configuration space reachable only by table read and table write
// - unimplemented word bits read zero, save in the absent secure word
// - without secure segment, the secure word is absent and reads all ones
// - boot write-protect one allows boot writes, zero blocks them
// - boot size with both low bits set means no boot flash segment
// - codes 110/010: 1K boot segment to its end, standard or high security
// - codes 101/001: 4K boot segment, standard or high security
// - codes 100/000: 8K boot segment, standard or high security
// - boot ram field: none, 128, 256 or 1024 bytes
// - secure write-protect one allows writes, zero blocks them
// - secure size low bits both set means no secure flash segment
// - codes 110/010: secure from boot end to 4K end address
// - codes 101/001: secure from boot end to 8K end address
// - codes 100/000: secure from boot end to 16K end address
// - secure ram: none, 256, 2048 or 4096 bytes less boot ram
`timescale 1ns/100ps

`include "spc_consts.vh"

module spc_segment_decode #(
	parameter HAS_SECURE = 1'b1                      // secure segment fitted
) (
	input  wire        clk_in,                       // 50 MHz clock
	input  wire        rst_in,                       // sync reset, active high
	input  wire        tbl_rd_in,                    // table read strobe
	input  wire        tbl_wr_in,                    // table write (program) strobe
	input  wire        fetch_in,                     // program fetch or data access
	input  wire [23:0] tbl_addr_in,                  // table address
	input  wire [7:0]  tbl_wdata_in,                 // word to program
	output reg  [7:0]  tbl_rdata_out,                // table read data
	output reg         tbl_ack_out,                  // table access answered
	input  wire [23:0] chk_addr_in,                  // flash address to check
	input  wire        chk_wr_in,                    // write attempt to chk_addr_in
	output reg         chk_block_out,                // write refused
	output reg         boot_present_out,             // boot flash segment exists
	output reg         boot_high_sec_out,            // boot high security
	output reg  [23:0] boot_end_out,                 // boot segment end address
	output reg         boot_wr_ok_out,               // boot writes allowed
	output reg  [12:0] boot_ram_bytes_out,           // protected boot ram size
	output reg         sec_present_out,              // secure flash segment exists
	output reg         sec_high_sec_out,             // secure high security
	output reg  [23:0] sec_end_out,                  // secure segment end address
	output reg         sec_wr_ok_out,                // secure writes allowed
	output reg  [12:0] sec_ram_bytes_out             // protected secure ram size
);

	// ************************************************************
	// nonvolatile word storage
	// ************************************************************
	reg [7:0] cfg_q [0:11];
	reg [7:0] rd_d;
	reg       hit_d;
	reg [3:0] idx_d;
	reg [7:0] mask_d;
	integer   i;

	// address to index, only even offsets in the window are words
	always @* begin
		hit_d = 1'b0;
		idx_d = 4'h0;
		if (tbl_addr_in >= `SPC_CFG_BASE && tbl_addr_in <= `SPC_CFG_LAST
		    && !tbl_addr_in[0]) begin
			hit_d = 1'b1;
			idx_d = tbl_addr_in[4:1];
		end
	end

	// mask per word index
	always @* begin
		case (idx_d)
		4'd0:    mask_d = `SPC_MASK_BOOT;
		4'd1:    mask_d = `SPC_MASK_SECURE;
		4'd2:    mask_d = `SPC_MASK_GENERAL;
		4'd3:    mask_d = `SPC_MASK_OSC_SEL;
		4'd4:    mask_d = `SPC_MASK_OSC;
		4'd5:    mask_d = `SPC_MASK_WDT;
		4'd6:    mask_d = `SPC_MASK_POR;
		4'd7:    mask_d = `SPC_MASK_DEBUG;
		default: mask_d = `SPC_MASK_UID;
		endcase
	end

	// read value: absent secure word reads ones, unused bits zero
	always @* begin
		if (!hit_d)
			rd_d = 8'h00;
		else if (idx_d == 4'd1 && !HAS_SECURE)
			rd_d = `SPC_ABSENT_WORD;
		else
			rd_d = cfg_q[idx_d] & mask_d;
	end

	// storage survives reset, as flash would; fetches never reach it
	always @(posedge clk_in) begin
		if (tbl_wr_in && !fetch_in && hit_d
		    && !(idx_d == 4'd1 && !HAS_SECURE))
			cfg_q[idx_d] <= tbl_wdata_in;
	end

	// erased flash starts all ones in simulation
	initial begin
		for (i = 0; i < 12; i = i + 1)
			cfg_q[i] = `SPC_ERASED_WORD;
	end

	// table port answer, one cycle after the strobe
	always @(posedge clk_in) begin
		if (rst_in) begin
			tbl_rdata_out <= 8'h00;
			tbl_ack_out   <= 1'b0;
		end else begin
			tbl_ack_out <= (tbl_rd_in | tbl_wr_in) & ~fetch_in;
			if (tbl_rd_in && !fetch_in)
				tbl_rdata_out <= rd_d;
		end
	end

	// ************************************************************
	// decode of boot and secure words
	// ************************************************************
	wire [7:0] boot_w = cfg_q[0];
	wire [7:0] sec_w  = HAS_SECURE ? cfg_q[1] : `SPC_ABSENT_WORD;
	wire [2:0] bsz    = boot_w[`SPC_SIZE_HI:`SPC_SIZE_LO];
	wire [2:0] ssz    = sec_w[`SPC_SIZE_HI:`SPC_SIZE_LO];
	wire [1:0] brs    = boot_w[`SPC_RAM_HI:`SPC_RAM_LO];
	wire [1:0] srs    = sec_w[`SPC_RAM_HI:`SPC_RAM_LO];
	wire        bpres_d;
	wire        bhigh_d;
	wire [23:0] bend_d;
	wire [12:0] bram_d;
	wire        spres_d;
	wire        shigh_d;
	wire [23:0] send_d;
	wire [12:0] sraw_d;
	reg  [12:0] sram_d;

	// boot flash: 1K, 4K or 8K instruction words from address zero
	spc_flash_size_decode #(
		.END_SMALL    (`SPC_END_1K),
		.END_MID      (`SPC_END_4K),
		.END_LARGE    (`SPC_END_8K)
	) u_boot_flash_size (
		.size_in      (bsz),
		.present_out  (bpres_d),
		.high_sec_out (bhigh_d),
		.end_out      (bend_d)
	);

	// secure flash: runs on from the boot end to the 4K, 8K or 16K end
	spc_flash_size_decode #(
		.END_SMALL    (`SPC_END_4K),
		.END_MID      (`SPC_END_8K),
		.END_LARGE    (`SPC_END_16K)
	) u_secure_flash_size (
		.size_in      (ssz),
		.present_out  (spres_d),
		.high_sec_out (shigh_d),
		.end_out      (send_d)
	);

	// boot ram: none, 128, 256 or 1024 bytes
	spc_ram_size_decode #(
		.SIZE_SMALL   (`SPC_BRAM_128),
		.SIZE_MID     (`SPC_BRAM_256),
		.SIZE_LARGE   (`SPC_BRAM_1024)
	) u_boot_ram_size (
		.code_in      (brs),
		.bytes_out    (bram_d)
	);

	// secure ram before the boot ram is taken off
	spc_ram_size_decode #(
		.SIZE_SMALL   (`SPC_SRAM_256),
		.SIZE_MID     (`SPC_SRAM_2048),
		.SIZE_LARGE   (`SPC_SRAM_4096)
	) u_secure_ram_size (
		.code_in      (srs),
		.bytes_out    (sraw_d)
	);

	// secure ram is net of boot ram; a boot area at least as large
	// leaves nothing rather than wrapping round to a huge size
	always @* begin
		if (sraw_d <= bram_d)
			sram_d = 13'd0;
		else
			sram_d = sraw_d - bram_d;
	end

	// ************************************************************
	// settings latched at reset; runtime programming waits for next reset
	// ************************************************************
	always @(posedge clk_in) begin
		if (rst_in) begin
			boot_present_out   <= bpres_d;
			boot_high_sec_out  <= bhigh_d;
			boot_end_out       <= bend_d;
			boot_wr_ok_out     <= boot_w[`SPC_WRP_BIT];
			boot_ram_bytes_out <= bram_d;
			sec_present_out    <= spres_d;
			sec_high_sec_out   <= shigh_d;
			sec_end_out        <= send_d;
			sec_wr_ok_out      <= sec_w[`SPC_WRP_BIT];
			sec_ram_bytes_out  <= sram_d;
		end
	end

	// ************************************************************
	// write check against latched segments
	// ************************************************************
	wire in_boot = boot_present_out && chk_addr_in <= boot_end_out;
	wire in_sec  = sec_present_out && !in_boot && chk_addr_in <= sec_end_out
	               && (!boot_present_out || chk_addr_in > boot_end_out);

	// refusal registered one cycle after the attempt
	always @(posedge clk_in) begin
		if (rst_in)
			chk_block_out <= 1'b0;
		else
			chk_block_out <= chk_wr_in &&
			    ((in_boot && !boot_wr_ok_out) ||
			     (in_sec && !sec_wr_ok_out));
	end

endmodule

// ************************************************************
// flash size code decode, one copy per segment word
// ************************************************************
// both low bits set means no segment; the top bit picks the
// security level, zero meaning high; an absent segment reports
// end address zero so the output is never left undefined
module spc_flash_size_decode #(
	parameter [23:0] END_SMALL = `SPC_END_1K,             // end for low bits 10
	parameter [23:0] END_MID   = `SPC_END_4K,             // end for low bits 01
	parameter [23:0] END_LARGE = `SPC_END_8K              // end for low bits 00
) (
	input  wire [2:0]  size_in,                           // size code field
	output reg         present_out,                       // segment defined
	output reg         high_sec_out,                      // high security chosen
	output reg  [23:0] end_out                            // last address, zero if none
);

	// low bits pick the end; both security levels share one end address
	always @* begin
		present_out  = 1'b1;
		high_sec_out = ~size_in[2];
		case (size_in[1:0])
		2'b10: begin
			end_out = END_SMALL;
		end
		2'b01: begin
			end_out = END_MID;
		end
		2'b00: begin
			end_out = END_LARGE;
		end
		default: begin
			present_out = 1'b0;
			end_out     = 24'h000000;
		end
		endcase
	end

endmodule

// ************************************************************
// ram size code decode, one copy per segment word
// ************************************************************
// both bits set means no protected ram; sizes are byte counts
module spc_ram_size_decode #(
	parameter [12:0] SIZE_SMALL = `SPC_BRAM_128,          // bytes for code 10
	parameter [12:0] SIZE_MID   = `SPC_BRAM_256,          // bytes for code 01
	parameter [12:0] SIZE_LARGE = `SPC_BRAM_1024          // bytes for code 00
) (
	input  wire [1:0]  code_in,                           // ram size code field
	output reg  [12:0] bytes_out                          // protected bytes, zero if none
);

	// plain lookup; thirteen bits hold the largest size
	always @* begin
		case (code_in)
		2'b10: begin
			bytes_out = SIZE_SMALL;
		end
		2'b01: begin
			bytes_out = SIZE_MID;
		end
		2'b00: begin
			bytes_out = SIZE_LARGE;
		end
		default: begin
			bytes_out = 13'd0;
		end
		endcase
	end

endmodule

// file: sim/spc_segment_decode_chk.sv
// Purpose: port checks for spc_segment_decode
// Assumes: answers are registered, one cycle late
// Notes:   bound from the bench top
`timescale 1ns/100ps
`include "spc_consts.vh"
module spc_segment_decode_chk (
	input wire        clk_in,           // clock
	input wire        rst_in,           // sync reset
	input wire        tbl_rd_in,        // table read
	input wire        tbl_wr_in,        // table write
	input wire        fetch_in,         // fetch access
	input wire [23:0] tbl_addr_in,      // table address
	input wire [7:0]  tbl_rdata_out,    // read data
	input wire        tbl_ack_out,      // answer
	input wire [23:0] chk_addr_in,      // checked address
	input wire        chk_wr_in,        // write attempt
	input wire        chk_block_out,    // refused
	input wire        boot_present_out, // boot exists
	input wire [23:0] boot_end_out,     // boot end
	input wire        boot_wr_ok_out,   // boot writable
	input wire        sec_present_out,  // secure exists
	input wire [23:0] sec_end_out,      // secure end
	input wire        sec_wr_ok_out     // secure writable
);
	// ************************************
	// checks
	// ************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// accepted read and out-of-map address
	wire rd_ok = tbl_rd_in && !fetch_in;
	wire miss  = tbl_addr_in < `SPC_CFG_BASE || tbl_addr_in > `SPC_CFG_LAST || tbl_addr_in[0];
	wire in_bt = chk_wr_in && boot_present_out && chk_addr_in <= boot_end_out;
	a_ack_follows: assert property ((tbl_rd_in || tbl_wr_in) && !fetch_in |=> tbl_ack_out)
		else $error("table access not answered");
	a_fetch_refused: assert property (fetch_in |=> !tbl_ack_out)
		else $error("fetch reached config space");
	a_unmapped_zero: assert property (rd_ok && miss |=> tbl_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	a_boot_unimpl: assert property (rd_ok && tbl_addr_in == `SPC_OFS_BOOT |=> !tbl_rdata_out[5:4])
		else $error("boot word spare bits set");
	a_debug_unimpl: assert property (rd_ok && tbl_addr_in == `SPC_OFS_DEBUG |=> !tbl_rdata_out[4:2])
		else $error("debug word spare bits set");
	a_decode_steady: assert property (!$past(rst_in) |-> $stable({boot_end_out, sec_end_out,
		boot_wr_ok_out, sec_wr_ok_out, boot_present_out, sec_present_out}))
		else $error("decode moved outside reset");
	a_boot_no_end: assert property (!boot_present_out |-> boot_end_out == 24'h000000)
		else $error("absent boot has an end");
	a_boot_blocked: assert property (in_bt && !boot_wr_ok_out |=> chk_block_out)
		else $error("boot write not blocked");
	a_boot_open: assert property (in_bt && boot_wr_ok_out |=> !chk_block_out)
		else $error("boot write wrongly blocked");
	a_sec_blocked: assert property (chk_wr_in && sec_present_out && !sec_wr_ok_out &&
		chk_addr_in > boot_end_out && chk_addr_in <= sec_end_out |=> chk_block_out)
		else $error("secure write not blocked");
	a_sec_open: assert property (chk_wr_in && sec_present_out && sec_wr_ok_out &&
		chk_addr_in > boot_end_out && chk_addr_in <= sec_end_out |=> !chk_block_out)
		else $error("secure write wrongly blocked");
endmodule

// file: sim/spc_segment_decode_tb_top.sv
// Purpose: self-checking bench for spc_segment_decode
// Assumes: erased words hold 0xff at start and read back as their masks
// Notes:   decode reloads only by pulsing reset
`timescale 1ns/100ps
`include "spc_consts.vh"
module spc_segment_decode_tb_top;
	// ************************************
	// stimulus and scoreboard
	// ************************************
	reg         clk_in, rst_in, tbl_rd_in, tbl_wr_in, fetch_in, chk_wr_in;
	reg  [23:0] tbl_addr_in, chk_addr_in, be, se;
	reg  [7:0]  tbl_wdata_in, bw, sw, mask [0:11];
	reg  [12:0] br, sr;
	reg  [8:0]  note, q [$];
	wire [7:0]  tbl_rdata_out;
	wire        tbl_ack_out, chk_block_out, boot_present_out, boot_high_sec_out, boot_wr_ok_out;
	wire        sec_present_out, sec_high_sec_out, sec_wr_ok_out;
	wire [23:0] boot_end_out, sec_end_out;
	wire [12:0] boot_ram_bytes_out, sec_ram_bytes_out;
	integer     seed = 32'hf6c8, bad_count = 0, num_checks = 0, i;
	spc_segment_decode u_spc_segment_decode (.clk_in(clk_in), .rst_in(rst_in),
		.tbl_rd_in(tbl_rd_in), .tbl_wr_in(tbl_wr_in), .fetch_in(fetch_in),
		.tbl_addr_in(tbl_addr_in), .tbl_wdata_in(tbl_wdata_in), .tbl_rdata_out(tbl_rdata_out),
		.tbl_ack_out(tbl_ack_out), .chk_addr_in(chk_addr_in), .chk_wr_in(chk_wr_in),
		.chk_block_out(chk_block_out), .boot_present_out(boot_present_out),
		.boot_high_sec_out(boot_high_sec_out), .boot_end_out(boot_end_out),
		.boot_wr_ok_out(boot_wr_ok_out), .boot_ram_bytes_out(boot_ram_bytes_out),
		.sec_present_out(sec_present_out), .sec_high_sec_out(sec_high_sec_out),
		.sec_end_out(sec_end_out), .sec_wr_ok_out(sec_wr_ok_out),
		.sec_ram_bytes_out(sec_ram_bytes_out));
	// small variant with no secure segment, fed the same stimulus
	wire [7:0]  sm_rdata;
	wire        sm_sec_present;
	spc_segment_decode #(.HAS_SECURE(1'b0)) u_spc_segment_decode_small (.clk_in(clk_in),
		.rst_in(rst_in), .tbl_rd_in(tbl_rd_in), .tbl_wr_in(tbl_wr_in), .fetch_in(fetch_in),
		.tbl_addr_in(tbl_addr_in), .tbl_wdata_in(tbl_wdata_in), .tbl_rdata_out(sm_rdata),
		.tbl_ack_out(), .chk_addr_in(chk_addr_in), .chk_wr_in(chk_wr_in), .chk_block_out(),
		.boot_present_out(), .boot_high_sec_out(), .boot_end_out(), .boot_wr_ok_out(),
		.boot_ram_bytes_out(), .sec_present_out(sm_sec_present), .sec_high_sec_out(),
		.sec_end_out(), .sec_wr_ok_out(), .sec_ram_bytes_out());
	task check(input [23:0] s, input [23:0] e);
		begin
			num_checks = num_checks + 1;
			if (s !== e) begin
				bad_count = bad_count + 1;
				$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
			end
		end
	endtask
	// strobes stay up so calls run back to back; idle lowers them
	task op(input w, input [23:0] a, input [7:0] d, input [8:0] e);
		begin
			if (!fetch_in) q.push_back(e);
			tbl_wr_in = w;
			tbl_rd_in = !w;
			tbl_addr_in = a;
			tbl_wdata_in = d;
			@(posedge clk_in) #1;
		end
	endtask
	task idle(input integer n);
		begin
			tbl_rd_in = 0;
			tbl_wr_in = 0;
			chk_wr_in = 0;
			repeat (n) @(posedge clk_in) #1;
		end
	endtask
	task wrap_up;
		begin
			$display("checks %0d mismatches %0d", num_checks, bad_count);
			if (bad_count == 0 && num_checks > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	// oldest note is paired with each answer, looked at mid-cycle once settled
	always @(negedge clk_in) if (tbl_ack_out === 1'b1) begin
		if (q.size() == 0) check(24'h1, 24'h0);
		else begin
			note = q.pop_front();
			if (note[8]) check(tbl_rdata_out, note[7:0]);
		end
	end
	initial begin
		clk_in = 0;
		forever #10 clk_in = ~clk_in;
	end
	initial begin
		repeat (20000) @(posedge clk_in);
		bad_count = bad_count + 1;
		wrap_up;
	end
	initial begin
		{rst_in, tbl_rd_in, tbl_wr_in, fetch_in, chk_wr_in} = 5'h10;
		{tbl_addr_in, chk_addr_in, tbl_wdata_in} = 0;
		{mask[0], mask[1], mask[2], mask[3]} = {8'hcf, 8'hcf, 8'h07, 8'h87};
		{mask[4], mask[5], mask[6], mask[7]} = {8'he7, 8'hdf, 8'hf7, 8'he3};
		for (i = 8; i < 12; i = i + 1) mask[i] = 8'hff;
		repeat (8) @(posedge clk_in) #1;
		rst_in = 0;
		for (i = 0; i < 12; i = i + 1) op(0, `SPC_CFG_BASE + 2 * i, 0, {1'b1, mask[i]});
		op(0, 24'hf80001, 0, 9'h100);
		op(0, 24'hf80018, 0, 9'h100);
		fetch_in = 1;
		op(1, `SPC_OFS_BOOT, 8'h00, 0);
		idle(1);
		fetch_in = 0;
		op(0, `SPC_OFS_BOOT, 0, 9'h1cf);
		bw = 8'hc0 | $random(seed); // implemented debug bits 7 and 6 kept high
		op(1, `SPC_OFS_DEBUG, bw, 0);
		op(0, `SPC_OFS_DEBUG, 0, {1'b1, bw & `SPC_MASK_DEBUG});
		for (i = 0; i < 8; i = i + 1) begin
			bw = $random(seed);
			bw[3:1] = i[2:0];
			sw = $random(seed);
			sw[3:1] = ~i[2:0];
			op(1, `SPC_OFS_BOOT, bw, 0);
			op(1, `SPC_OFS_SECURE, sw, 0);
			idle(1);
			rst_in = 1;
			idle(2);
			rst_in = 0;
			be = bw[2:1] == 2 ? 24'h0007fe : bw[2:1] == 1 ? 24'h001ffe : bw[2:1] == 0 ? 24'h003ffe : 0;
			se = sw[2:1] == 2 ? 24'h001ffe : sw[2:1] == 1 ? 24'h003ffe : sw[2:1] == 0 ? 24'h007ffe : 0;
			br = bw[7:6] == 3 ? 0 : bw[7:6] == 2 ? 128 : bw[7:6] == 1 ? 256 : 1024;
			sr = sw[7:6] == 3 ? 0 : sw[7:6] == 2 ? 256 : sw[7:6] == 1 ? 2048 : 4096;
			sr = sr > br ? sr - br : 0;
			check(boot_present_out, bw[2:1] != 3);
			check(boot_end_out, be);
			if (bw[2:1] != 3) check(boot_high_sec_out, !bw[3]);
			check(boot_wr_ok_out, bw[0]);
			check(boot_ram_bytes_out, br);
			check(sec_present_out, sw[2:1] != 3);
			if (sw[2:1] != 3) check(sec_end_out, se);
			if (sw[2:1] != 3) check(sec_high_sec_out, !sw[3]);
			check(sec_wr_ok_out, sw[0]);
			check(sec_ram_bytes_out, sr);
			chk_wr_in = 1;
			chk_addr_in = 0;
			@(posedge clk_in) #1;
			if (bw[2:1] != 3) check(chk_block_out, !bw[0]);
			chk_addr_in = se;
			@(posedge clk_in) #1;
			if (sw[2:1] != 3 && se > be) check(chk_block_out, !sw[0]);
			repeat (4) begin
				chk_addr_in = $random(seed) & 24'h007fff;
				@(posedge clk_in) #1;
			end
			idle(1);
		end
		op(0, `SPC_OFS_SECURE, 0, {1'b1, sw & `SPC_MASK_SECURE});
		check(sm_rdata, `SPC_ABSENT_WORD);
		check(sm_sec_present, 0);
		idle(2);
		check(q.size(), 0);
		wrap_up;
	end
endmodule
bind spc_segment_decode spc_segment_decode_chk u_spc_segment_decode_chk (.clk_in(clk_in),
	.rst_in(rst_in), .tbl_rd_in(tbl_rd_in), .tbl_wr_in(tbl_wr_in), .fetch_in(fetch_in),
	.tbl_addr_in(tbl_addr_in), .tbl_rdata_out(tbl_rdata_out), .tbl_ack_out(tbl_ack_out),
	.chk_addr_in(chk_addr_in), .chk_wr_in(chk_wr_in), .chk_block_out(chk_block_out),
	.boot_present_out(boot_present_out), .boot_end_out(boot_end_out),
	.boot_wr_ok_out(boot_wr_ok_out), .sec_present_out(sec_present_out),
	.sec_end_out(sec_end_out), .sec_wr_ok_out(sec_wr_ok_out));
